// [verilog/pmu_consts.svh]
// Register addresses, field positions and fixed values of the performance-monitoring unit
`ifndef PMU_CONSTS_SVH
`define PMU_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define PMU_ADDR_W           12
`define PMU_A_GLOBAL_STATUS  12'h38E
`define PMU_A_GLOBAL_ENABLE  12'h38F
`define PMU_A_OVF_CLEAR      12'h390
`define PMU_A_PRECISE_EN     12'h3F1
`define PMU_A_EVTSEL0        12'h186
`define PMU_A_EVTSEL1        12'h187
`define PMU_A_GEN_CNT0       12'h0C1
`define PMU_A_GEN_CNT1       12'h0C2
`define PMU_A_FIX_CNT0       12'h309
`define PMU_A_FIX_CNT1       12'h30A
`define PMU_A_FIX_CNT2       12'h30B
`define PMU_A_FIX_CTRL       12'h38D
`define PMU_A_DEBUG_CTRL     12'h1D9
`define PMU_A_MISC_ENABLE    12'h1A0
`define PMU_A_MON_ID         12'h00A

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMU_ES_USR           16
`define PMU_ES_OS            17
`define PMU_ES_ANY_THREAD    21
`define PMU_ES_INT           20
`define PMU_ES_EN            22
`define PMU_FIX_BASE         32
`define PMU_ST_BUF_OVF       62
`define PMU_DBG_FREEZE       12
`define PMU_MISC_MON_AVAIL   7
`define PMU_MISC_PREC_UNAV   12

// ----------------------------------------------------------------------
// Sizes and fixed values
// ----------------------------------------------------------------------
`define PMU_CNT_W            40
`define PMU_NUM_GEN          2
`define PMU_NUM_FIX          3
`define PMU_NUM_EVT          16
`define PMU_VERSION_ID       8'h03
`define PMU_GEN_COUNT        8'h02
`define PMU_FIX_COUNT        8'h03
`define PMU_CNT_WIDTH_ID     8'h28

`endif

// [verilog/pmu_pkg.sv]
// Shared types of the performance-monitoring unit
`default_nettype none
`include "pmu_consts.svh"
package pmu_pkg;
    typedef logic [63:0]               pmu_word_t;
    typedef logic [`PMU_CNT_W-1:0]     pmu_cnt_t;
    typedef logic [`PMU_ADDR_W-1:0]    pmu_addr_t;
endpackage
`default_nettype wire

// [verilog/pmu_cnt_if.sv]
// Control and result signals between the unit and one counter
`timescale 1ns/1ps
`default_nettype none
interface pmu_cnt_if;
    import pmu_pkg::*;
    logic     load;      // Software write of a new value
    pmu_cnt_t load_val;  // Value to load
    logic     inc;       // One qualifying occurrence
    pmu_cnt_t value;     // Current count
    logic     wrap;      // Pulse after wrapping past maximum

    modport ctrl    (output load, load_val, inc, input value, wrap);
    modport counter (input load, load_val, inc, output value, wrap);
endinterface
`default_nettype wire

// [verilog/pmu_counter.sv]
// One performance counter with load and wrap detection
`timescale 1ns/1ps
`default_nettype none
module pmu_counter
    import pmu_pkg::*;
(
    input  wire logic  clk_i,   // System clock
    input  wire logic  rst_n_i, // Synchronous reset, active low
    pmu_cnt_if.counter cif      // Counter control and result
);

    // ----------------------------------------------------------------------
    // Count, load and wrap
    // ----------------------------------------------------------------------
    // Load wins over an increment in the same cycle so the written value is exact
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cif.value <= '0;
            cif.wrap  <= 1'b0;
        end else if (cif.load) begin
            cif.value <= cif.load_val;
            cif.wrap  <= 1'b0;
        end else if (cif.inc) begin
            cif.value <= cif.value + pmu_cnt_t'(1);
            cif.wrap  <= &cif.value;
        end else begin
            cif.wrap  <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [verilog/pmu_top.sv]
// Performance-monitoring unit with precise sampling and global counter control
`timescale 1ns/1ps
`default_nettype none
`include "pmu_consts.svh"
module pmu_top
    import pmu_pkg::*;
(
    input  wire logic                     SYS_CLK_I,      // System clock
    input  wire logic                     NRST_I,         // Synchronous reset, active low
    input  wire logic                     MSR_WR_I,       // Register write strobe
    input  wire logic                     MSR_RD_I,       // Register read strobe
    input  wire logic [`PMU_ADDR_W-1:0]   MSR_ADDR_I,     // Register address
    input  wire logic [63:0]              MSR_WDATA_I,    // Write data
    input  wire logic [`PMU_NUM_EVT-1:0]  EVENT_I,        // Event pulses, this thread
    input  wire logic [`PMU_NUM_EVT-1:0]  EVENT_OTHER_I,  // Event pulses, other thread
    input  wire logic [`PMU_NUM_FIX-1:0]  FIX_EVENT_I,    // Fixed-counter event pulses
    input  wire logic [`PMU_NUM_FIX-1:0]  FIX_OTHER_I,    // Fixed events, other thread
    input  wire logic                     USER_MODE_I,    // High in user privilege
    input  wire logic                     BRANCH_TRACE_REQ_I, // Branch-trace store request
    output logic     [63:0]               MSR_RDATA_O,    // Read data
    output logic                          MSR_RVALID_O,   // Read data valid pulse
    output logic                          MSR_FAULT_O,    // Unmapped access or read-only write pulse
    output logic                          PERF_INT_O      // Shared interrupt pulse
);

    localparam int NC = `PMU_NUM_GEN + `PMU_NUM_FIX;

    // ----------------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------------
    pmu_word_t                  status_q;
    pmu_word_t                  enable_q;
    logic                       precise_q;
    pmu_word_t                  evtsel_q [`PMU_NUM_GEN];
    logic [4*`PMU_NUM_FIX-1:0]  fix_ctrl_q;
    logic                       freeze_q;
    logic [NC-1:0]              inc_d;
    logic [NC-1:0]              load_d;
    logic [NC-1:0]              wrap_w;
    logic [NC-1:0]              int_en_w;
    pmu_cnt_t                   val_w [NC];
    logic                       irq_d;
    logic                       precise_evt_w;

    // Counter slots 0..1 general, 2..4 fixed
    function automatic int stpos(input int i);
        return (i < `PMU_NUM_GEN) ? i : `PMU_FIX_BASE + i - `PMU_NUM_GEN;
    endfunction

    // ----------------------------------------------------------------------
    // Counter instances
    // ----------------------------------------------------------------------
    for (genvar g = 0; g < NC; g++) begin : g_cnt
        pmu_cnt_if cif ();
        pmu_counter u_cnt (
            .clk_i   (SYS_CLK_I),
            .rst_n_i (NRST_I),
            .cif     (cif.counter)
        );
        assign cif.load     = load_d[g];
        assign cif.load_val = MSR_WDATA_I[`PMU_CNT_W-1:0];
        assign cif.inc      = inc_d[g];
        assign val_w[g]     = cif.value;
        assign wrap_w[g]    = cif.wrap;
    end

    // ----------------------------------------------------------------------
    // Event qualification
    // ----------------------------------------------------------------------
    // Selects above the wired event range count nothing rather than alias
    always_comb begin
        logic [7:0] sel;
        logic       hit;
        logic       priv;
        sel      = 8'h00;
        hit      = 1'b0;
        priv     = 1'b0;
        inc_d    = '0;
        int_en_w = '0;
        // Separate loops keep every index inside its own array
        for (int i = 0; i < `PMU_NUM_GEN; i++) begin
            sel = evtsel_q[i][7:0];
            hit = (sel < 8'(`PMU_NUM_EVT)) &&
                  (EVENT_I[sel[3:0]] ||
                   (evtsel_q[i][`PMU_ES_ANY_THREAD] &&
                    EVENT_OTHER_I[sel[3:0]]));
            priv = USER_MODE_I ? evtsel_q[i][`PMU_ES_USR]
                               : evtsel_q[i][`PMU_ES_OS];
            inc_d[i] = hit && priv && evtsel_q[i][`PMU_ES_EN]
                       && enable_q[stpos(i)];
            int_en_w[i] = evtsel_q[i][`PMU_ES_INT] || (i == 0 && precise_q);
        end
        for (int j = 0; j < `PMU_NUM_FIX; j++) begin
            hit = FIX_EVENT_I[j] || (fix_ctrl_q[4*j+2] && FIX_OTHER_I[j]);
            priv = USER_MODE_I ? fix_ctrl_q[4*j+1] : fix_ctrl_q[4*j];
            inc_d[`PMU_NUM_GEN+j] = hit && priv && enable_q[stpos(`PMU_NUM_GEN+j)];
            int_en_w[`PMU_NUM_GEN+j] = fix_ctrl_q[4*j+3];
        end
    end

    // ----------------------------------------------------------------------
    // Counter loads from software writes
    // ----------------------------------------------------------------------
    // Loading a running counter is allowed; software is expected to stop it first
    always_comb begin
        load_d    = '0;
        load_d[0] = MSR_WR_I && (MSR_ADDR_I == `PMU_A_GEN_CNT0);
        load_d[1] = MSR_WR_I && (MSR_ADDR_I == `PMU_A_GEN_CNT1);
        load_d[2] = MSR_WR_I && (MSR_ADDR_I == `PMU_A_FIX_CNT0);
        load_d[3] = MSR_WR_I && (MSR_ADDR_I == `PMU_A_FIX_CNT1);
        load_d[4] = MSR_WR_I && (MSR_ADDR_I == `PMU_A_FIX_CNT2);
    end

    // ----------------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------------
    // One output for every source so a single handler serves them all
    assign precise_evt_w = precise_q && wrap_w[0];
    assign irq_d = (|(wrap_w & int_en_w)) || BRANCH_TRACE_REQ_I;

    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            PERF_INT_O <= 1'b0;
        end else begin
            PERF_INT_O <= irq_d;
        end
    end

    // ----------------------------------------------------------------------
    // Global overflow status
    // ----------------------------------------------------------------------
    // Hardware set wins over a clear landing in the same cycle
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            status_q <= '0;
        end else begin
            pmu_word_t nxt;
            nxt = status_q;
            if (MSR_WR_I && MSR_ADDR_I == `PMU_A_OVF_CLEAR) begin
                nxt = nxt & ~MSR_WDATA_I;
            end
            for (int i = 0; i < NC; i++) begin
                if (wrap_w[i]) begin
                    nxt[stpos(i)] = 1'b1;
                end
            end
            if (precise_evt_w) begin
                nxt[0]               = 1'b0;
                nxt[`PMU_ST_BUF_OVF] = 1'b1;
            end
            status_q <= nxt;
        end
    end

    // ----------------------------------------------------------------------
    // Global enable with freeze on interrupt
    // ----------------------------------------------------------------------
    // Freeze takes priority so a write in the interrupt cycle cannot restart
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            enable_q <= '0;
        end else if (freeze_q && irq_d) begin
            enable_q <= '0;
        end else if (MSR_WR_I && MSR_ADDR_I == `PMU_A_GLOBAL_ENABLE) begin
            enable_q <= '0;
            for (int i = 0; i < NC; i++) begin
                enable_q[stpos(i)] <= MSR_WDATA_I[stpos(i)];
            end
        end
    end

    // ----------------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            precise_q   <= 1'b0;
            evtsel_q[0] <= '0;
            evtsel_q[1] <= '0;
            fix_ctrl_q  <= '0;
            freeze_q    <= 1'b0;
        end else if (MSR_WR_I) begin
            case (MSR_ADDR_I)
                `PMU_A_PRECISE_EN: precise_q   <= MSR_WDATA_I[0];
                `PMU_A_EVTSEL0:    evtsel_q[0] <= {32'h0000_0000, MSR_WDATA_I[31:0]};
                `PMU_A_EVTSEL1:    evtsel_q[1] <= {32'h0000_0000, MSR_WDATA_I[31:0]};
                `PMU_A_FIX_CTRL:   fix_ctrl_q  <= MSR_WDATA_I[4*`PMU_NUM_FIX-1:0];
                `PMU_A_DEBUG_CTRL: freeze_q    <= MSR_WDATA_I[`PMU_DBG_FREEZE];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // Read port and access faults
    // ----------------------------------------------------------------------
    // Counter reads give the registered value, so a late event may be missed
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            MSR_RDATA_O  <= 64'h0000_0000_0000_0000;
            MSR_RVALID_O <= 1'b0;
        end else begin
            MSR_RVALID_O <= MSR_RD_I;
            if (MSR_RD_I) begin
                case (MSR_ADDR_I)
                    `PMU_A_GLOBAL_STATUS: MSR_RDATA_O <= status_q;
                    `PMU_A_GLOBAL_ENABLE: MSR_RDATA_O <= enable_q;
                    `PMU_A_PRECISE_EN:    MSR_RDATA_O <= {63'h0, precise_q};
                    `PMU_A_EVTSEL0:       MSR_RDATA_O <= evtsel_q[0];
                    `PMU_A_EVTSEL1:       MSR_RDATA_O <= evtsel_q[1];
                    `PMU_A_GEN_CNT0:      MSR_RDATA_O <= 64'(val_w[0]);
                    `PMU_A_GEN_CNT1:      MSR_RDATA_O <= 64'(val_w[1]);
                    `PMU_A_FIX_CNT0:      MSR_RDATA_O <= 64'(val_w[2]);
                    `PMU_A_FIX_CNT1:      MSR_RDATA_O <= 64'(val_w[3]);
                    `PMU_A_FIX_CNT2:      MSR_RDATA_O <= 64'(val_w[4]);
                    `PMU_A_FIX_CTRL:      MSR_RDATA_O <= 64'(fix_ctrl_q);
                    `PMU_A_DEBUG_CTRL:    MSR_RDATA_O <= 64'(freeze_q) << `PMU_DBG_FREEZE;
                    `PMU_A_MISC_ENABLE:   MSR_RDATA_O <= 64'h1 << `PMU_MISC_MON_AVAIL;
                    `PMU_A_MON_ID:        MSR_RDATA_O <= {32'h0, `PMU_FIX_COUNT,
                                                          `PMU_CNT_WIDTH_ID,
                                                          `PMU_GEN_COUNT,
                                                          `PMU_VERSION_ID};
                    default:              MSR_RDATA_O <= 64'h0000_0000_0000_0000;
                endcase
            end
        end
    end

    // Unmapped addresses and writes to read-only registers report a fault
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            MSR_FAULT_O <= 1'b0;
        end else begin
            case (MSR_ADDR_I)
                `PMU_A_GLOBAL_STATUS, `PMU_A_MISC_ENABLE, `PMU_A_MON_ID:
                    MSR_FAULT_O <= MSR_WR_I;
                `PMU_A_GLOBAL_ENABLE, `PMU_A_OVF_CLEAR, `PMU_A_PRECISE_EN,
                `PMU_A_EVTSEL0, `PMU_A_EVTSEL1, `PMU_A_GEN_CNT0, `PMU_A_GEN_CNT1,
                `PMU_A_FIX_CNT0, `PMU_A_FIX_CNT1, `PMU_A_FIX_CNT2,
                `PMU_A_FIX_CTRL, `PMU_A_DEBUG_CTRL:
                    MSR_FAULT_O <= 1'b0;
                default:
                    MSR_FAULT_O <= MSR_WR_I || MSR_RD_I;
            endcase
        end
    end

endmodule
`default_nettype wire

// [dv/pmu_top_asserts.sv]
// Concurrent checks on the register port and interrupt of the monitoring unit
`timescale 1ns/1ps
`default_nettype none
`include "pmu_consts.svh"
module pmu_top_asserts
    import pmu_pkg::*;
(
    input wire logic                   SYS_CLK_I,          // System clock
    input wire logic                   NRST_I,             // Reset, active low
    input wire logic                   MSR_WR_I,           // Write strobe
    input wire logic                   MSR_RD_I,           // Read strobe
    input wire logic [`PMU_ADDR_W-1:0] MSR_ADDR_I,         // Register address
    input wire logic [63:0]            MSR_WDATA_I,        // Write data
    input wire logic                   BRANCH_TRACE_REQ_I, // Branch-trace request
    input wire logic [63:0]            MSR_RDATA_O,        // Read data
    input wire logic                   MSR_RVALID_O,       // Read valid
    input wire logic                   MSR_FAULT_O,        // Access fault
    input wire logic                   PERF_INT_O          // Shared interrupt
);
    // ----------------------------------------------------------------
    // Sequences and properties
    // ----------------------------------------------------------------
    default clocking dc @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);

    // Register steps; an idle cycle sits between write and read-back
    sequence s_zero_en;
        MSR_WR_I && MSR_ADDR_I == `PMU_A_GLOBAL_ENABLE && MSR_WDATA_I == 64'h0;
    endsequence
    sequence s_rd(logic [`PMU_ADDR_W-1:0] a);
        MSR_RD_I && MSR_ADDR_I == a;
    endsequence
    sequence s_wr_prec;
        MSR_WR_I && MSR_ADDR_I == `PMU_A_PRECISE_EN;
    endsequence

    property p_rd_answer;
        MSR_RD_I |=> MSR_RVALID_O;
    endproperty
    property p_no_stray;
        !MSR_RD_I |=> !MSR_RVALID_O;
    endproperty
    property p_misc;
        s_rd(`PMU_A_MISC_ENABLE) |=> MSR_RDATA_O == 64'h80;
    endproperty
    property p_ident;
        s_rd(`PMU_A_MON_ID) |=> MSR_RDATA_O[7:0] == `PMU_VERSION_ID
            && MSR_RDATA_O[15:8] == `PMU_GEN_COUNT && MSR_RDATA_O[31:24] == `PMU_FIX_COUNT;
    endproperty
    property p_status_ro;
        MSR_WR_I && MSR_ADDR_I == `PMU_A_GLOBAL_STATUS |=> MSR_FAULT_O;
    endproperty
    property p_clear_wo;
        s_rd(`PMU_A_OVF_CLEAR) |=> MSR_RDATA_O == 64'h0 && !MSR_FAULT_O;
    endproperty
    property p_branch_int;
        BRANCH_TRACE_REQ_I |=> PERF_INT_O;
    endproperty
    // Freeze may also zero the enables, so zero stays the only legal answer
    property p_disable_all;
        s_zero_en ##1 !MSR_WR_I ##1 s_rd(`PMU_A_GLOBAL_ENABLE) |=> MSR_RDATA_O == 64'h0;
    endproperty
    property p_prec_back;
        s_wr_prec ##1 !MSR_WR_I ##1 s_rd(`PMU_A_PRECISE_EN)
            |=> MSR_RDATA_O[0] == $past(MSR_WDATA_I[0], 3);
    endproperty

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_no_stray: assert property (p_no_stray) else $error("stray read valid");
    a_misc: assert property (p_misc) else $error("misc enable value wrong");
    a_ident: assert property (p_ident) else $error("ident fields wrong");
    a_status_ro: assert property (p_status_ro) else $error("status write not refused");
    a_clear_wo: assert property (p_clear_wo) else $error("clear reg read wrong");
    a_branch_int: assert property (p_branch_int) else $error("branch int missing");
    a_disable_all: assert property (p_disable_all) else $error("enable not zero");
    a_prec_back: assert property (p_prec_back) else $error("precise bit lost");
endmodule

bind pmu_top pmu_top_asserts u_pmu_chk (
    .SYS_CLK_I          (SYS_CLK_I),
    .NRST_I             (NRST_I),
    .MSR_WR_I           (MSR_WR_I),
    .MSR_RD_I           (MSR_RD_I),
    .MSR_ADDR_I         (MSR_ADDR_I),
    .MSR_WDATA_I        (MSR_WDATA_I),
    .BRANCH_TRACE_REQ_I (BRANCH_TRACE_REQ_I),
    .MSR_RDATA_O        (MSR_RDATA_O),
    .MSR_RVALID_O       (MSR_RVALID_O),
    .MSR_FAULT_O        (MSR_FAULT_O),
    .PERF_INT_O         (PERF_INT_O)
);
`default_nettype wire

// [dv/test_pmu_top.sv]
// Self-checking testbench for the performance-monitoring unit
`timescale 1ns/1ps
`default_nettype none
`include "pmu_consts.svh"
module test_pmu_top;
    import pmu_pkg::*;
    logic clk, rst_n, wr_s, rd_s, user_m, br_req, rvalid, fault, pint;
    pmu_addr_t  addr;
    pmu_word_t  wdata, rdata;
    logic [15:0] ev, ev_oth;
    logic [2:0]  fx, fx_oth;
    int          mismatches;
    int          n_tests;
    localparam pmu_word_t ONES = 64'hFF_FFFF_FFFF;

    pmu_top DUT (.SYS_CLK_I(clk), .NRST_I(rst_n), .MSR_WR_I(wr_s), .MSR_RD_I(rd_s),
        .MSR_ADDR_I(addr), .MSR_WDATA_I(wdata), .EVENT_I(ev), .EVENT_OTHER_I(ev_oth),
        .FIX_EVENT_I(fx), .FIX_OTHER_I(fx_oth), .USER_MODE_I(user_m),
        .BRANCH_TRACE_REQ_I(br_req), .MSR_RDATA_O(rdata), .MSR_RVALID_O(rvalid),
        .MSR_FAULT_O(fault), .PERF_INT_O(pint));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input pmu_word_t exp, input pmu_word_t got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One access; answers are looked at 1 ns after the edge that samples the strobe
    task automatic acc(input logic w, input pmu_addr_t a, input pmu_word_t d,
                       input logic flt, output pmu_word_t v);
        wr_s <= w;
        rd_s <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        #1;
        chk("fault", 64'(flt), 64'(fault));
        if (!w) chk("rvalid", 64'h1, 64'(rvalid));
        v = rdata;
        @(posedge clk);
    endtask

    task automatic wr(input pmu_addr_t a, input pmu_word_t d);
        pmu_word_t v;
        acc(1'b1, a, d, 1'b0, v);
    endtask

    task automatic rdc(input string nm, input pmu_addr_t a, input pmu_word_t exp);
        pmu_word_t v;
        acc(1'b0, a, 64'h0, 1'b0, v);
        chk(nm, exp, v);
    endtask

    // One-cycle event pulse; exp[1] interrupt at once, exp[0] one cycle later
    task automatic fire(input logic [15:0] e, input logic [15:0] o, input logic [2:0] f,
                        input logic b, input logic [1:0] exp);
        ev <= e;
        ev_oth <= o;
        fx <= f;
        br_req <= b;
        @(posedge clk);
        ev <= '0;
        ev_oth <= '0;
        fx <= '0;
        br_req <= 1'b0;
        #1;
        chk("int_now", 64'(exp[1]), 64'(pint));
        @(posedge clk);
        #1;
        chk("int_next", 64'(exp[0]), 64'(pint));
        @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_ident();
        pmu_word_t v;
        rdc("misc", `PMU_A_MISC_ENABLE, 64'h80);
        rdc("ident", `PMU_A_MON_ID, 64'h0328_0203);
        acc(1'b1, `PMU_A_GLOBAL_STATUS, ONES, 1'b1, v);
        rdc("clr_rd", `PMU_A_OVF_CLEAR, 64'h0);
        acc(1'b0, 12'h123, 64'h0, 1'b1, v);
        chk("unmapped", 64'h0, v);
        $display("t_ident done");
    endtask

    task automatic t_gen_ovf();
        wr(`PMU_A_EVTSEL0, 64'h53_0000);
        wr(`PMU_A_GEN_CNT0, ONES);
        wr(`PMU_A_GLOBAL_ENABLE, 64'h1);
        fire(16'h1, 16'h0, 3'b0, 1'b0, 2'b01);
        rdc("cnt0", `PMU_A_GEN_CNT0, 64'h0);
        rdc("stat", `PMU_A_GLOBAL_STATUS, 64'h1);
        wr(`PMU_A_OVF_CLEAR, 64'h1);
        rdc("stat_clr", `PMU_A_GLOBAL_STATUS, 64'h0);
        $display("t_gen_ovf done");
    endtask

    // User-only select with thread qualifier on counter 1
    task automatic t_thread();
        wr(`PMU_A_EVTSEL1, 64'h61_0001);
        wr(`PMU_A_GEN_CNT1, 64'h0);
        wr(`PMU_A_GLOBAL_ENABLE, 64'h2);
        user_m <= 1'b0;
        fire(16'h2, 16'h0, 3'b0, 1'b0, 2'b00);
        user_m <= 1'b1;
        fire(16'h2, 16'h0, 3'b0, 1'b0, 2'b00);
        fire(16'h0, 16'h2, 3'b0, 1'b0, 2'b00);
        fire(16'h1, 16'h0, 3'b0, 1'b0, 2'b00);
        wr(`PMU_A_GLOBAL_ENABLE, 64'h0);
        rdc("en_zero", `PMU_A_GLOBAL_ENABLE, 64'h0);
        fire(16'h2, 16'h2, 3'b0, 1'b0, 2'b00);
        rdc("cnt1", `PMU_A_GEN_CNT1, 64'h2);
        $display("t_thread done");
    endtask

    task automatic t_precise();
        wr(`PMU_A_EVTSEL0, 64'h43_0000);
        wr(`PMU_A_PRECISE_EN, 64'h1);
        rdc("prec", `PMU_A_PRECISE_EN, 64'h1);
        wr(`PMU_A_GEN_CNT0, ONES);
        wr(`PMU_A_GLOBAL_ENABLE, 64'h1);
        fire(16'h1, 16'h0, 3'b0, 1'b0, 2'b01);
        rdc("stat_buf", `PMU_A_GLOBAL_STATUS, 64'h4000_0000_0000_0000);
        wr(`PMU_A_OVF_CLEAR, ~64'h0);
        rdc("stat_clr", `PMU_A_GLOBAL_STATUS, 64'h0);
        wr(`PMU_A_GLOBAL_ENABLE, 64'h0);
        wr(`PMU_A_PRECISE_EN, 64'h0);
        wr(`PMU_A_GEN_CNT0, ONES);
        wr(`PMU_A_GLOBAL_ENABLE, 64'h1);
        fire(16'h1, 16'h0, 3'b0, 1'b0, 2'b00);
        rdc("stat_np", `PMU_A_GLOBAL_STATUS, 64'h1);
        wr(`PMU_A_GLOBAL_ENABLE, 64'h0);
        wr(`PMU_A_OVF_CLEAR, ~64'h0);
        $display("t_precise done");
    endtask

    // Fixed counter 0 wraps with freeze set; enables must drop
    task automatic t_fix_freeze();
        wr(`PMU_A_FIX_CTRL, 64'hA);
        wr(`PMU_A_FIX_CNT0, ONES);
        wr(`PMU_A_DEBUG_CTRL, 64'h1000);
        wr(`PMU_A_GLOBAL_ENABLE, 64'h1_0000_0000);
        fire(16'h0, 16'h0, 3'b001, 1'b0, 2'b01);
        rdc("fix0", `PMU_A_FIX_CNT0, 64'h0);
        rdc("stat_fix", `PMU_A_GLOBAL_STATUS, 64'h1_0000_0000);
        rdc("frozen", `PMU_A_GLOBAL_ENABLE, 64'h0);
        wr(`PMU_A_OVF_CLEAR, ~64'h0);
        fire(16'h0, 16'h0, 3'b0, 1'b1, 2'b10);
        $display("t_fix_freeze done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // About 130 cycles expected; over twenty times that marks a hang
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        {rst_n, wr_s, rd_s, br_req} = 4'b0;
        {addr, wdata, ev, ev_oth, fx, fx_oth} = '0;
        user_m = 1'b1;
        mismatches = 0;
        n_tests = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_ident();
        t_gen_ovf();
        t_thread();
        t_precise();
        t_fix_freeze();
        tally_and_finish();
    end
endmodule
`default_nettype wire
